// *** logic/cirm_pkg.sv ***
`default_nettype none
package cirm_pkg;
    // storage geometry; the top bits of a word are ordinary data
    localparam int DW    = 18;
    localparam int HW    = 9;
    localparam int AW    = 8;
    localparam int DEPTH = 256;
    localparam int NRD   = 2;

    // register offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] RSTV_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;

    // values after reset
    localparam logic [7:0]    CTRL_RST = 8'h00;
    localparam logic [DW-1:0] RSTV_RST = 18'h0_0000;

    // control field positions
    localparam int MODE_A_LSB = 0;
    localparam int MODE_B_LSB = 2;
    localparam int STYLE_BIT  = 4;
    localparam int OREG_BIT   = 5;
    localparam int BWR_BIT    = 6;
    localparam int ASYM_BIT   = 7;

    // status field positions
    localparam int DONE_BIT  = 16;
    localparam int COUNT_LSB = 0;

    typedef enum logic [1:0] {
        CIRM_READ_FIRST,
        CIRM_WRITE_FIRST,
        CIRM_NO_CHANGE
    } cirm_mode_e;

    // contents loaded into every word before use
    function automatic logic [DW-1:0] cirm_init_word(input logic [AW-1:0] a);
        return {2'b00, a, a};
    endfunction
endpackage
`default_nettype wire

// *** logic/cirm_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module cirm_regs (
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    output logic      [7:0]              ctrl_o,
    output logic      [cirm_pkg::DW-1:0] rstv_o,
    input  wire logic                    init_done_i,
    input  wire logic [15:0]             wr_count_i
);
    logic [31:0]             dat_r;
    logic                    ack_r;
    logic [7:0]              ctrl_r;
    logic [cirm_pkg::DW-1:0] rstv_r;

    // address decode and byte-lane mask
    wire        req    = wb_cyc_i & wb_stb_i;
    wire        wr_hit = req & ack_r & wb_we_i;
    wire        hit_c  = wb_adr_i == cirm_pkg::CTRL_OFS;
    wire        hit_v  = wb_adr_i == cirm_pkg::RSTV_OFS;
    wire        hit_s  = wb_adr_i == cirm_pkg::STAT_OFS;
    wire [31:0] wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] stat_w = {15'h0000, init_done_i, wr_count_i};

    // read mux; unmapped words read as zero
    wire [31:0] rd_w = hit_c ? {24'h00_0000, ctrl_r} :
                       hit_v ? {14'h0000, rstv_r} :
                       hit_s ? stat_w : 32'h0000_0000;

    wire [7:0]              ctrl_nxt = (ctrl_r & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
    wire [cirm_pkg::DW-1:0] rstv_nxt = (rstv_r & ~wmask[cirm_pkg::DW-1:0])
                                     | (wb_dat_i[cirm_pkg::DW-1:0] & wmask[cirm_pkg::DW-1:0]);

    // ack one cycle after the request; the write lands on the edge
    // where the master sees ack, so both views agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_r  <= 1'b0;
            dat_r  <= 32'h0000_0000;
            ctrl_r <= cirm_pkg::CTRL_RST;
            rstv_r <= cirm_pkg::RSTV_RST;
        end else begin
            ack_r <= req & ~ack_r;
            dat_r <= rd_w;
            if (wr_hit && hit_c) begin
                ctrl_r <= ctrl_nxt;
            end
            if (wr_hit && hit_v) begin
                rstv_r <= rstv_nxt;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign ctrl_o   = ctrl_r;
    assign rstv_o   = rstv_r;
endmodule
`default_nettype wire

// *** logic/cirm_ram.sv ***
// Summary of operation
// - writes land only on a clock edge
// - distributed style reads follow address combinationally
// - block style read data changes on edges
// - async read is distributed; sync selectable
// - read-first shows old word on write
// - write-first shows incoming write data
// - no-change holds output while writing
// - sync mode chosen per port
// - single, simple dual, true dual ports
// - one writer allows extra read ports
// - each port has own controls
// - port B may use half width
// - optional extra output register stage
// - top bits are plain data, no parity
// - initial contents loaded before use
// - output reset loads constant, memory untouched
`timescale 1ns/1ps
`default_nettype none
module cirm_ram (
    input  wire logic                                      clk,
    input  wire logic                                      rst_b,
    input  wire logic                                      wb_cyc_i,
    input  wire logic                                      wb_stb_i,
    input  wire logic                                      wb_we_i,
    input  wire logic [7:0]                                wb_adr_i,
    input  wire logic [3:0]                                wb_sel_i,
    input  wire logic [31:0]                               wb_dat_i,
    output logic      [31:0]                               wb_dat_o,
    output logic                                           wb_ack_o,
    input  wire logic                                      a_en,
    input  wire logic                                      a_we,
    input  wire logic                                      a_rst,
    input  wire logic [cirm_pkg::AW-1:0]                   a_addr,
    input  wire logic [cirm_pkg::DW-1:0]                   a_write_data_in,
    output logic      [cirm_pkg::DW-1:0]                   a_rdata,
    input  wire logic                                      b_en,
    input  wire logic                                      b_we,
    input  wire logic                                      b_rst,
    input  wire logic [cirm_pkg::AW:0]                     b_addr,
    input  wire logic [cirm_pkg::DW-1:0]                   b_write_data_in,
    output logic      [cirm_pkg::DW-1:0]                   b_rdata,
    input  wire logic [cirm_pkg::NRD-1:0][cirm_pkg::AW-1:0] rd_addr,
    output logic      [cirm_pkg::NRD-1:0][cirm_pkg::DW-1:0] rd_data,
    output logic                                           init_done
);
    localparam int DW = cirm_pkg::DW;
    localparam int HW = cirm_pkg::HW;
    localparam int AW = cirm_pkg::AW;

    // storage; every bit, the top ones too, holds data
    logic [DW-1:0] mem [cirm_pkg::DEPTH];

    logic [7:0]    ctrl;
    logic [DW-1:0] rstv;
    logic [AW:0]   init_cnt_r;
    logic [15:0]   wr_cnt_r;

    cirm_regs u_regs (
        .clk         (clk),
        .rst_b       (rst_b),
        .wb_cyc_i    (wb_cyc_i),
        .wb_stb_i    (wb_stb_i),
        .wb_we_i     (wb_we_i),
        .wb_adr_i    (wb_adr_i),
        .wb_sel_i    (wb_sel_i),
        .wb_dat_i    (wb_dat_i),
        .wb_dat_o    (wb_dat_o),
        .wb_ack_o    (wb_ack_o),
        .ctrl_o      (ctrl),
        .rstv_o      (rstv),
        .init_done_i (init_done),
        .wr_count_i  (wr_cnt_r)
    );

    // control decode
    // per-port mode fields
    cirm_pkg::cirm_mode_e mode [2];
    assign mode[0] = cirm_pkg::cirm_mode_e'(ctrl[cirm_pkg::MODE_A_LSB +: 2]);
    assign mode[1] = cirm_pkg::cirm_mode_e'(ctrl[cirm_pkg::MODE_B_LSB +: 2]);
    wire style_blk = ctrl[cirm_pkg::STYLE_BIT];
    wire oreg      = ctrl[cirm_pkg::OREG_BIT];
    wire b_wr_on   = ctrl[cirm_pkg::BWR_BIT];
    wire asym      = ctrl[cirm_pkg::ASYM_BIT];

    // per-port controls; ports stay idle until the fill is done
    // independent enable, strobe, reset
    logic [1:0]    en;
    logic [1:0]    we;
    logic [1:0]    orst;
    logic [1:0]    wr;
    logic [AW-1:0] idx   [2];
    logic [DW-1:0] word  [2];
    logic [DW-1:0] wword [2];
    logic [DW-1:0] wview [2];
    logic [DW-1:0] rview [2];
    assign en   = {b_en & init_done, a_en & init_done};
    // port B writes only when enabled, at most two writers
    assign we   = {b_we & b_wr_on, a_we};
    assign orst = {b_rst, a_rst};
    assign wr   = en & we;

    // port A sees whole words
    assign idx[0]   = a_addr;
    assign word[0]  = mem[idx[0]];
    assign wword[0] = a_write_data_in;
    assign wview[0] = a_write_data_in;
    assign rview[0] = word[0];

    // port B half width merges into the stored word
    // narrow view over same storage
    wire          b_hi = b_addr[0];
    wire [HW-1:0] b_lo = b_write_data_in[HW-1:0];
    wire [HW-1:0] b_half = b_hi ? word[1][DW-1:HW] : word[1][HW-1:0];
    assign idx[1]   = asym ? b_addr[AW:1] : b_addr[AW-1:0];
    assign word[1]  = mem[idx[1]];
    assign wword[1] = !asym ? b_write_data_in :
                      b_hi ? {b_lo, word[1][HW-1:0]} : {word[1][DW-1:HW], b_lo};
    assign wview[1] = asym ? {{HW{1'b0}}, b_lo} : b_write_data_in;
    assign rview[1] = asym ? {{HW{1'b0}}, b_half} : word[1];

    // fill walk; the top bit of the counter marks completion
    assign init_done = init_cnt_r[AW];
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            init_cnt_r <= '0;
        end else if (!init_done) begin
            init_cnt_r <= init_cnt_r + 1'b1;
        end
    end

    // write port; on a same-word clash port A lands last and wins
    // commit on the edge only
    always_ff @(posedge clk) begin
        if (!init_done) begin
            mem[init_cnt_r[AW-1:0]] <= cirm_pkg::cirm_init_word(init_cnt_r[AW-1:0]);
        end else begin
            if (wr[1]) begin
                mem[idx[1]] <= wword[1];
            end
            if (wr[0]) begin
                mem[idx[0]] <= wword[0];
            end
        end
    end

    // write counter shown in status
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_cnt_r <= 16'h0000;
        end else begin
            wr_cnt_r <= wr_cnt_r + 16'(wr[0] | wr[1]);
        end
    end

    // synchronous read path for both ports
    logic [DW-1:0] q_r   [2];
    logic [DW-1:0] p_r   [2];
    logic [DW-1:0] q_nxt [2];
    logic [DW-1:0] dout  [2];
    for (genvar i = 0; i < 2; i++) begin : g_port
        assign q_nxt[i] = !en[i] ? q_r[i] :
                          orst[i] ? rstv :
                          (mode[i] == cirm_pkg::CIRM_WRITE_FIRST && we[i]) ? wview[i] :
                          (mode[i] == cirm_pkg::CIRM_NO_CHANGE && we[i]) ? q_r[i] :
                          rview[i];
        // data valid one edge after address
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                q_r[i] <= '0;
                p_r[i] <= '0;
            end else begin
                q_r[i] <= q_nxt[i];
                p_r[i] <= q_r[i];
            end
        end
        assign dout[i] = !style_blk ? rview[i] : oreg ? p_r[i] : q_r[i];
    end
    assign a_rdata = dout[0];
    assign b_rdata = dout[1];

    // extra read ports exist only while port B cannot write
    // independent read addresses
    for (genvar j = 0; j < cirm_pkg::NRD; j++) begin : g_rd
        assign rd_data[j] = b_wr_on ? '0 : mem[rd_addr[j]];
    end

    a_rf_old: assert property (@(posedge clk) disable iff (!rst_b)
        (en[0] && we[0] && !orst[0] && mode[0] == cirm_pkg::CIRM_READ_FIRST)
        |=> q_r[0] == $past(word[0]))
        else $error("read-first did not show the old word");

    a_wf_new: assert property (@(posedge clk) disable iff (!rst_b)
        (en[0] && we[0] && !orst[0] && mode[0] == cirm_pkg::CIRM_WRITE_FIRST)
        |=> q_r[0] == $past(a_write_data_in))
        else $error("write-first did not forward write data");

    a_nc_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (en[0] && we[0] && !orst[0] && mode[0] == cirm_pkg::CIRM_NO_CHANGE)
        |=> $stable(q_r[0]))
        else $error("no-change output moved on a write");

    a_orst_load: assert property (@(posedge clk) disable iff (!rst_b)
        (en[0] && orst[0]) |=> q_r[0] == $past(rstv))
        else $error("output reset did not load the constant");

    a_en_gate: assert property (@(posedge clk) disable iff (!rst_b)
        !en[0] |=> $stable(q_r[0]))
        else $error("read register moved while disabled");

    a_no_write: assert property (@(posedge clk) disable iff (!rst_b)
        (init_done && !wr[0] && !wr[1]) ##1 $stable(a_addr) |-> $stable(word[0]))
        else $error("word changed with no write");

    a_dist_follow: assert property (@(posedge clk) disable iff (!rst_b)
        (!style_blk && wr[0] && !wr[1]) ##1 (!style_blk && a_addr == $past(a_addr))
        |-> a_rdata == $past(a_write_data_in))
        else $error("distributed read missed the written word");

    a_oreg_lat: assert property (@(posedge clk) disable iff (!rst_b)
        (style_blk && oreg) ##1 (style_blk && oreg) |-> a_rdata == $past(q_r[0]))
        else $error("output register stage not one cycle");

    a_init_fill: assert property (@(posedge clk) disable iff (!rst_b)
        (!init_done && init_cnt_r[AW-1:0] == a_addr) ##1 $stable(a_addr)
        |-> word[0] == cirm_pkg::cirm_init_word($past(a_addr)))
        else $error("initial word not loaded");

    // port B mirrors of the port A read-write checks
    a_rf_old_b: assert property (@(posedge clk) disable iff (!rst_b)
        (en[1] && we[1] && !orst[1] && mode[1] != cirm_pkg::CIRM_WRITE_FIRST
            && mode[1] != cirm_pkg::CIRM_NO_CHANGE)
        |=> q_r[1] == $past(rview[1]))
        else $error("port B read-first did not show the old word");

    a_wf_new_b: assert property (@(posedge clk) disable iff (!rst_b)
        (en[1] && we[1] && !orst[1] && mode[1] == cirm_pkg::CIRM_WRITE_FIRST)
        |=> q_r[1] == $past(wview[1]))
        else $error("port B write-first did not forward write data");

    a_nc_hold_b: assert property (@(posedge clk) disable iff (!rst_b)
        (en[1] && we[1] && !orst[1] && mode[1] == cirm_pkg::CIRM_NO_CHANGE)
        |=> $stable(q_r[1]))
        else $error("port B no-change output moved on a write");

    a_orst_b: assert property (@(posedge clk) disable iff (!rst_b)
        (en[1] && orst[1]) |=> q_r[1] == $past(rstv))
        else $error("port B output reset did not load the constant");

    a_en_gate_b: assert property (@(posedge clk) disable iff (!rst_b)
        !en[1] |=> $stable(q_r[1]))
        else $error("port B read register moved while disabled");

    a_oreg_lat_b: assert property (@(posedge clk) disable iff (!rst_b)
        (style_blk && oreg) ##1 (style_blk && oreg) |-> b_rdata == $past(q_r[1]))
        else $error("port B output register stage not one cycle");

    // plain read edges load the addressed word in every mode
    a_rd_upd: assert property (@(posedge clk) disable iff (!rst_b)
        (en[0] && !we[0] && !orst[0]) |=> q_r[0] == $past(rview[0]))
        else $error("read edge did not load the addressed word");

    a_rd_upd_b: assert property (@(posedge clk) disable iff (!rst_b)
        (en[1] && !we[1] && !orst[1]) |=> q_r[1] == $past(rview[1]))
        else $error("port B read edge did not load the addressed word");

    // storage checks; write order in the write process settles a clash
    a_clash_a_wins: assert property (@(posedge clk) disable iff (!rst_b)
        (wr[0] && wr[1] && idx[0] == idx[1])
        |=> mem[$past(idx[0])] == $past(wword[0]))
        else $error("port A did not win a same-word clash");

    // a half-width write must leave the other half alone
    a_half_merge: assert property (@(posedge clk) disable iff (!rst_b)
        (wr[1] && !(wr[0] && idx[0] == idx[1]))
        |=> mem[$past(idx[1])] == $past(wword[1]))
        else $error("port B write did not land as merged");

    a_orst_keep: assert property (@(posedge clk) disable iff (!rst_b)
        (en[0] && orst[0] && !wr[0] && !wr[1]) |=> mem[$past(idx[0])] == $past(word[0]))
        else $error("output reset disturbed the stored word");

    a_rd_indep: assert property (@(posedge clk) disable iff (!rst_b)
        (!b_wr_on && wr[0] && rd_addr[0] == idx[0]) ##1 $stable(rd_addr[0])
        |-> rd_data[0] == $past(a_write_data_in))
        else $error("extra read port missed the written word");

    a_fill_done: assert property (@(posedge clk) disable iff (!rst_b)
        init_done |=> init_done)
        else $error("fill done flag dropped");

    a_fill_walk: assert property (@(posedge clk) disable iff (!rst_b)
        !init_done |=> init_cnt_r == $past(init_cnt_r) + 9'h001)
        else $error("fill walk skipped a word");
endmodule
`default_nettype wire

// *** testbench/cirm_user.sv ***
`timescale 1ns/1ps
`default_nettype none
// user logic on port A (index 0) and port B (index 1)
module cirm_user (
    output var logic [1:0]       en,
    output var logic [1:0]       we,
    output var logic [1:0]       rs,
    output var logic [1:0][8:0]  ad,
    output var logic [1:0][17:0] dt
);
    // quiet ports until the bench starts traffic
    initial begin
        en = '0;
        we = '0;
        rs = '0;
        ad = '0;
        dt = '0;
    end

    // caller reads one edge per output stage later
    // idle address and data flip, so a stale value never looks valid
    task automatic put(input int p, input logic e, w, r, input logic [8:0] a, input logic [17:0] d);
        en[p] <= e;
        we[p] <= w;
        rs[p] <= r;
        ad[p] <= e ? a : ~ad[p];
        dt[p] <= e ? d : ~dt[p];
    endtask
endmodule
`default_nettype wire

// *** testbench/cirm_ram_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module cirm_ram_bench;
    logic             clk = 1'b0;
    logic             rst_b = 1'b0;
    logic             cyc = 1'b0;
    logic             stb = 1'b0;
    logic             wen = 1'b0;
    logic [7:0]       adr = 8'h00;
    logic [3:0]       sel = 4'hf;
    logic [31:0]      wdat = 32'h0000_0000;
    logic [31:0]      rdat;
    logic             ack;
    logic [1:0][7:0]  rd_addr = 16'h0000;
    logic [1:0][17:0] rd_data;
    logic [17:0]      a_q;
    logic [17:0]      b_q;
    logic             init_done;
    logic [1:0]       en, we, rs;
    logic [1:0][8:0]  ad;
    logic [1:0][17:0] dt;
    logic [17:0]      shadow [256];
    logic [31:0]      seed = 32'h0000_000d;
    int               err_count = 0;
    int               checks = 0;

    always #4 clk = ~clk;

    cirm_user user (.en(en), .we(we), .rs(rs), .ad(ad), .dt(dt));
    cirm_ram uut (
        .clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wen), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .a_en(en[0]), .a_we(we[0]), .a_rst(rs[0]), .a_addr(ad[0][7:0]),
        .a_write_data_in(dt[0]), .a_rdata(a_q),
        .b_en(en[1]), .b_we(we[1]), .b_rst(rs[1]), .b_addr(ad[1]),
        .b_write_data_in(dt[1]), .b_rdata(b_q),
        .rd_addr(rd_addr), .rd_data(rd_data), .init_done(init_done));

    // xorshift keeps every run identical
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // word seen on a written edge: old word, incoming data or held output
    function automatic logic [17:0] exp_q(input logic [1:0] m, input logic [17:0] old, din, prev);
        if (m == 2'd1) return din;
        if (m == 2'd2) return prev;
        return old;
    endfunction

    task automatic check(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        wen <= w;
        adr <= a;
        wdat <= d;
        for (n = 0; n < 20 && ack !== 1'b1; n++) begin
            @(posedge clk);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            err_count++;
            stop_test();
        end
    endtask

    // one edge on both ports with the given enables, then idle; checks land 1 ns later
    task automatic mem(input logic [1:0] e, w, r, input logic [8:0] aa, ab, input logic [17:0] da, db);
        @(posedge clk);
        user.put(0, e[0], w[0], r[0], aa, da);
        user.put(1, e[1], w[1], r[1], ab, db);
        @(posedge clk);
        user.put(0, 1'b0, 1'b0, 1'b0, aa, da);
        user.put(1, 1'b0, 1'b0, 1'b0, ab, db);
        #1;
    endtask

    initial begin
        logic [31:0] q;
        logic [31:0] v;
        logic [7:0]  x;
        logic [17:0] e;
        logic [1:0]  mb;
        int          m;
        int          n;
        for (n = 0; n < 256; n++) begin
            shadow[n] = {2'b00, n[7:0], n[7:0]};
        end
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        for (n = 0; n < 400 && init_done !== 1'b1; n++) begin
            @(posedge clk);
        end
        check(init_done, 1'b1);
        if (init_done !== 1'b1) begin
            stop_test();
        end
        // registers: control reset value, read-only status, unmapped hole
        wb(1'b0, 8'h00, 32'h0000_0000, q);
        check(q, 32'h0000_0000);
        wb(1'b1, 8'h08, 32'h0000_0000, q);
        wb(1'b0, 8'h08, 32'h0000_0000, q);
        check(q[16], 1'b1);
        wb(1'b0, 8'h0c, 32'h0000_0000, q);
        check(q, 32'h0000_0000);
        $display("test registers done");
        // distributed reads on both extra ports, no edge needed
        for (n = 0; n < 8; n++) begin
            v = rnd();
            @(posedge clk);
            rd_addr <= {v[7:0], v[15:8]};
            #1;
            check(rd_data[1], shadow[v[7:0]]);
            check(rd_data[0], shadow[v[15:8]]);
        end
        // distributed write lands only at the edge, top bits plain data
        v = rnd();
        x = v[25:18];
        @(posedge clk);
        user.put(0, 1'b1, 1'b1, 1'b0, {1'b0, x}, v[17:0]);
        rd_addr <= {x, x};
        #1;
        check(rd_data[0], shadow[x]);
        @(posedge clk);
        user.put(0, 1'b1, 1'b0, 1'b0, {1'b0, x}, 18'h0_0000);
        #1;
        check(rd_data[0], v[17:0]);
        check(a_q, v[17:0]);
        shadow[x] = v[17:0];
        @(posedge clk);
        user.put(0, 1'b0, 1'b0, 1'b0, 9'h000, 18'h0_0000);
        $display("test distributed done");
        // block style, both ports writing, every mode code on A and B
        for (m = 0; m < 4; m++) begin
            mb = 2'(m + 1);
            wb(1'b1, 8'h00, {24'h00_0000, 4'h5, mb, m[1:0]}, q);
            v = rnd();
            x = v[7:0];
            mem(2'b11, 2'b00, 2'b00, {1'b0, x ^ 8'h01}, {v[8], x ^ 8'h03}, 18'h0_0000, 18'h0_0000);
            check(a_q, shadow[x ^ 8'h01]);
            check(b_q, shadow[x ^ 8'h03]);
            v = rnd();
            mem(2'b11, 2'b11, 2'b00, {1'b0, x}, {1'b1, x ^ 8'h02}, v[17:0], v[31:14]);
            e = exp_q(m[1:0], shadow[x], v[17:0], shadow[x ^ 8'h01]);
            check(a_q, e);
            check(b_q, exp_q(mb, shadow[x ^ 8'h02], v[31:14], shadow[x ^ 8'h03]));
            shadow[x] = v[17:0];
            shadow[x ^ 8'h02] = v[31:14];
            @(posedge clk);
            #1;
            check(a_q, e);
        end
        $display("test modes done");
        // output reset loads the constant and leaves the word alone
        v = rnd();
        wb(1'b1, 8'h04, {14'h0000, v[17:0]}, q);
        wb(1'b0, 8'h04, 32'h0000_0000, q);
        check(q, {14'h0000, v[17:0]});
        mem(2'b11, 2'b00, 2'b11, {1'b0, x}, {1'b0, x}, 18'h0_0000, 18'h0_0000);
        check(a_q, v[17:0]);
        check(b_q, v[17:0]);
        mem(2'b11, 2'b00, 2'b00, {1'b0, x}, {1'b0, x}, 18'h0_0000, 18'h0_0000);
        check(a_q, shadow[x]);
        check(b_q, shadow[x]);
        $display("test output reset done");
        // both ports write one word on one edge: port A lands last
        v = rnd();
        mem(2'b11, 2'b11, 2'b00, {1'b0, x}, {1'b0, x}, v[17:0], v[31:14]);
        check(b_q, shadow[x]);
        mem(2'b01, 2'b00, 2'b00, {1'b0, x}, 9'h000, 18'h0_0000, 18'h0_0000);
        check(a_q, v[17:0]);
        shadow[x] = v[17:0];
        $display("test clash done");
        // extra output stage adds one cycle of latency
        wb(1'b1, 8'h00, 32'h0000_0030, q);
        mem(2'b01, 2'b00, 2'b00, {1'b0, x ^ 8'h05}, 9'h000, 18'h0_0000, 18'h0_0000);
        check(a_q, shadow[x]);
        @(posedge clk);
        #1;
        check(a_q, shadow[x ^ 8'h05]);
        $display("test output stage done");
        // half-width port B reads both halves
        wb(1'b1, 8'h00, 32'h0000_0090, q);
        for (n = 0; n < 4; n++) begin
            v = rnd();
            mem(2'b10, 2'b00, 2'b00, 9'h000, {v[7:0], n[0]}, 18'h0_0000, 18'h0_0000);
            e = n[0] ? {9'h000, shadow[v[7:0]][17:9]} : {9'h000, shadow[v[7:0]][8:0]};
            check(b_q, e);
        end
        // half-width write merges into one half; extra read ports go quiet
        wb(1'b1, 8'h00, 32'h0000_00d0, q);
        v = rnd();
        x = v[17:10];
        mem(2'b10, 2'b10, 2'b00, 9'h000, {x, 1'b1}, 18'h0_0000, {9'h000, v[8:0]});
        check(rd_data[0], 18'h0_0000);
        check(b_q, {9'h000, shadow[x][17:9]});
        shadow[x] = {v[8:0], shadow[x][8:0]};
        mem(2'b01, 2'b00, 2'b00, {1'b0, x}, 9'h000, 18'h0_0000, 18'h0_0000);
        check(a_q, shadow[x]);
        $display("test half width done");
        stop_test();
    end
endmodule
`default_nettype wire
